// File: core/mca_consts.svh
// constants for the multiplexed divider, output selector and ac sync block
`ifndef MCA_CONSTS_SVH
`define MCA_CONSTS_SVH

`define MCA_NDIV      8
`define MCA_NOUT      8
`define MCA_SELW      6
`define MCA_TICKW     8
`define MCA_PHW       16
`define MCA_CLK_HZ    125000000
`define MCA_TICK_HZ   1000000
`define MCA_STEP_US   100
`define MCA_DIV_SYNC  7

`define MCA_SEL_BUS0  6'h20
`define MCA_SEL_BUS7  6'h27
`define MCA_SEL_DIV0  6'h28
`define MCA_SEL_DIV7  6'h2F
`define MCA_SEL_AC    6'h30
`define MCA_SEL_ONE   6'h3E
`define MCA_SEL_ZERO  6'h3F

`define MCA_A_CTRL    12'h000
`define MCA_A_STAT    12'h004
`define MCA_A_POL     12'h008
`define MCA_A_ACDIV   12'h00C
`define MCA_A_ACPH    12'h010
`define MCA_A_DVAL    12'h020
`define MCA_A_SEL     12'h040
`define MCA_A_PAGE    12'hFE0

`define MCA_C_SWRST   0
`define MCA_C_BYP     1
`define MCA_C_SYN7    2
`define MCA_C_T0AC    3

`endif

// File: core/mca_pkg.sv
// types of the multiplexed divider block
package mca_pkg;
`include "mca_consts.svh"

  typedef struct packed {
    logic [`MCA_NDIV-1:0][31:0]            dval;
    logic [`MCA_NDIV-1:0][30:0]            cnt;
    logic [`MCA_NDIV-1:0]                  tog;
    logic [`MCA_NDIV-1:0]                  tog_d1;
    logic [`MCA_NDIV-1:0]                  half;
    logic [`MCA_NDIV-1:0]                  pol;
    logic [`MCA_NOUT-1:0][`MCA_SELW-1:0]   sel;
    logic [3:0]                            ctrl;
    logic [7:0]                            ac_ratio;
    logic [7:0]                            ac_phase;
    logic [2:0]                            ac_s;
    logic [2:0]                            hr_s;
    logic                                  ac_f;
    logic                                  ac_f_d1;
    logic                                  hr_f;
    logic [7:0]                            ac_cnt;
    logic [`MCA_TICKW-1:0]                 tick_cnt;
    logic                                  tick;
    logic [`MCA_PHW-1:0]                   ph_cnt;
    logic                                  ph_arm;
    logic                                  ac_pend;
    logic                                  ac_pls;
    logic                                  swrst;
    logic [`MCA_NOUT-1:0]                  pin;
    logic [`MCA_NDIV-1:0]                  trig;
    logic [`MCA_NDIV-1:0]                  seqt;
    logic [31:0]                           prdata;
    logic                                  pready;
    logic                                  pslverr;
  } mca_state_t;

endpackage

// File: core/mca_top.sv
// divide-by-n clock generators, output selectors and ac line sync with apb registers
`timescale 1ns/1ps
`include "mca_consts.svh"

module mca_top #(
  parameter int TICK_DIV   = `MCA_CLK_HZ / `MCA_TICK_HZ,
  parameter int STEP_TICKS = `MCA_STEP_US * `MCA_TICK_HZ / 1000000
) (
  input  wire logic                 pclk,
  input  wire logic                 presetn,
  input  wire logic                 psel,
  input  wire logic                 penable,
  input  wire logic                 pwrite,
  input  wire logic [11:0]          paddr,
  input  wire logic [31:0]          pwdata,
  output logic      [31:0]          prdata,
  output logic                      pready,
  output logic                      pslverr,
  input  wire logic [`MCA_NDIV-1:0] shared_bus_in,
  input  wire logic                 ac_line_in,
  input  wire logic                 div_reset_in,
  output logic      [`MCA_NOUT-1:0] out_pin,
  output logic      [`MCA_NDIV-1:0] trig_event,
  output logic      [`MCA_NDIV-1:0] seq_trigger,
  output logic      [`MCA_NDIV-1:0] divider_clock_generator,
  output logic                      ac_trigger
);

  localparam logic [`MCA_TICKW-1:0] TICK_LAST  = `MCA_TICKW'(TICK_DIV - 1);
  localparam logic [`MCA_PHW-1:0]   STEP_COUNT = `MCA_PHW'(STEP_TICKS);

  mca_pkg::mca_state_t s_q;
  mca_pkg::mca_state_t s_d;

  // ************************************************************
  // next state
  // ************************************************************
  always_comb
  begin
    logic                 div_rst;
    logic                 ac_rise;
    logic                 div_evt;
    logic                 shifted;
    logic                 ac_src;
    logic                 rise7;
    logic [30:0]          norm;
    logic [8:0]           ac_next;
    logic [`MCA_PHW-1:0]  ph_load;
    logic                 setup;
    logic                 access;
    logic [2:0]           widx;
    div_rst = 1'b0;
    ac_rise = 1'b0;
    div_evt = 1'b0;
    shifted = 1'b0;
    ac_src  = 1'b0;
    rise7   = 1'b0;
    norm    = '0;
    ac_next = '0;
    ph_load = '0;
    setup   = 1'b0;
    access  = 1'b0;
    widx    = '0;
    s_d     = s_q;

    s_d.swrst   = 1'b0;
    s_d.pready  = 1'b0;
    s_d.pslverr = 1'b0;

    // ************************************************************
    // pin synchronisers
    // ************************************************************
    // external input sampling
    s_d.ac_s = {s_q.ac_s[1:0], ac_line_in};
    s_d.hr_s = {s_q.hr_s[1:0], div_reset_in};
    if (s_q.ac_s[1] == s_q.ac_s[2])
    begin
      s_d.ac_f = s_q.ac_s[2];
    end
    if (s_q.hr_s[1] == s_q.hr_s[2])
    begin
      s_d.hr_f = s_q.hr_s[2];
    end
    s_d.ac_f_d1 = s_q.ac_f;
    ac_rise     = s_q.ac_f & ~s_q.ac_f_d1;

    // ************************************************************
    // dividers
    // ************************************************************
    // software pulse or hardware level
    div_rst = s_q.swrst | s_q.hr_f;
    for (int i = 0; i < `MCA_NDIV; i++)
    begin
      norm        = s_q.dval[i][31:1] - 31'h0000_0001;
      s_d.tog_d1[i] = s_q.tog[i];
      if (div_rst)
      begin
        s_d.tog[i]  = s_q.pol[i];
        s_d.half[i] = 1'b0;
        s_d.cnt[i]  = norm;
      end
      else if (s_q.cnt[i] == 31'h0000_0000)
      begin
        s_d.tog[i]  = ~s_q.tog[i];
        s_d.half[i] = ~s_q.half[i];
        if (~s_q.half[i] & s_q.dval[i][0])
        begin
          s_d.cnt[i] = s_q.dval[i][31:1];
        end
        else
        begin
          s_d.cnt[i] = norm;
        end
      end
      else
      begin
        s_d.cnt[i] = s_q.cnt[i] - 31'h0000_0001;
      end
      s_d.trig[i] = s_q.tog[i] & ~s_q.tog_d1[i];
      s_d.seqt[i] = s_q.tog[i] & ~s_q.tog_d1[i];
    end
    // divider 7 edge for ac sync
    rise7 = s_q.tog[`MCA_DIV_SYNC] & ~s_q.tog_d1[`MCA_DIV_SYNC];

    // ************************************************************
    // ac line path
    // ************************************************************
    // 1 MHz tick as an enable
    s_d.tick = 1'b0;
    if (s_q.tick_cnt >= TICK_LAST)
    begin
      s_d.tick_cnt = '0;
      s_d.tick     = 1'b1;
    end
    else
    begin
      s_d.tick_cnt = s_q.tick_cnt + `MCA_TICKW'(1);
    end

    ac_next = {1'b0, s_q.ac_cnt} + 9'h001;
    if (ac_rise)
    begin
      if (ac_next >= {1'b0, s_q.ac_ratio})
      begin
        div_evt    = 1'b1;
        s_d.ac_cnt = 8'h00;
      end
      else
      begin
        s_d.ac_cnt = ac_next[7:0];
      end
    end

    ph_load = `MCA_PHW'(s_q.ac_phase * STEP_COUNT);
    if (div_evt)
    begin
      s_d.ph_cnt = ph_load;
      s_d.ph_arm = 1'b1;
    end
    else if (s_q.ph_arm & s_q.tick)
    begin
      if (s_q.ph_cnt == '0)
      begin
        shifted    = 1'b1;
        s_d.ph_arm = 1'b0;
      end
      else
      begin
        s_d.ph_cnt = s_q.ph_cnt - `MCA_PHW'(1);
      end
    end

    if (s_q.ctrl[`MCA_C_BYP])
    begin
      ac_src = ac_rise;
    end
    else
    begin
      ac_src = shifted;
    end

    // sync to clock or divider 7
    s_d.ac_pls = 1'b0;
    if (s_q.ctrl[`MCA_C_SYN7])
    begin
      if (rise7 & s_q.ac_pend)
      begin
        s_d.ac_pls  = 1'b1;
        s_d.ac_pend = 1'b0;
      end
      // a new edge in the release cycle is kept
      if (ac_src)
      begin
        s_d.ac_pend = 1'b1;
      end
    end
    else
    begin
      s_d.ac_pls  = ac_src;
      s_d.ac_pend = 1'b0;
    end

    // trigger 0 on ac sync output
    if (s_q.ctrl[`MCA_C_T0AC] & s_q.ac_pls)
    begin
      s_d.trig[0] = 1'b1;
    end

    // ************************************************************
    // output selectors
    // ************************************************************
    // one selector per output
    for (int j = 0; j < `MCA_NOUT; j++)
    begin
      if (s_q.sel[j] >= `MCA_SEL_BUS0 && s_q.sel[j] <= `MCA_SEL_BUS7)
      begin
        s_d.pin[j] = shared_bus_in[s_q.sel[j][2:0]];
      end
      else if (s_q.sel[j] >= `MCA_SEL_DIV0 && s_q.sel[j] <= `MCA_SEL_DIV7)
      begin
        s_d.pin[j] = s_q.tog[s_q.sel[j][2:0]];
      end
      else if (s_q.sel[j] == `MCA_SEL_AC)
      begin
        s_d.pin[j] = s_q.ac_pls;
      end
      else if (s_q.sel[j] == `MCA_SEL_ONE)
      begin
        s_d.pin[j] = 1'b1;
      end
      else
      begin
        s_d.pin[j] = 1'b0;
      end
    end

    // ************************************************************
    // apb slave
    // ************************************************************
    // answer is ready in the first access cycle
    setup  = psel & ~penable;
    access = psel & penable & s_q.pready;
    widx   = paddr[4:2];
    if (setup)
    begin
      s_d.pready = 1'b1;
      s_d.prdata = 32'h0000_0000;
      if (paddr == `MCA_A_CTRL)
      begin
        s_d.prdata[3:1] = s_q.ctrl[3:1];
      end
      else if (paddr == `MCA_A_STAT)
      begin
        s_d.prdata[`MCA_NDIV-1:0] = s_q.tog;
        s_d.prdata[`MCA_NDIV]     = s_q.ac_pend;
        s_d.prdata[`MCA_NDIV+1]   = s_q.ph_arm;
      end
      else if (paddr == `MCA_A_POL)
      begin
        s_d.prdata[`MCA_NDIV-1:0] = s_q.pol;
      end
      else if (paddr == `MCA_A_ACDIV)
      begin
        s_d.prdata[7:0] = s_q.ac_ratio;
      end
      else if (paddr == `MCA_A_ACPH)
      begin
        s_d.prdata[7:0] = s_q.ac_phase;
      end
      else if ((paddr & `MCA_A_PAGE) == `MCA_A_DVAL)
      begin
        s_d.prdata = s_q.dval[widx];
      end
      else if ((paddr & `MCA_A_PAGE) == `MCA_A_SEL)
      begin
        s_d.prdata[`MCA_SELW-1:0] = s_q.sel[widx];
      end
      else
      begin
        s_d.pslverr = 1'b1;
      end
    end
    if (access & pwrite)
    begin
      if (paddr == `MCA_A_CTRL)
      begin
        s_d.ctrl  = pwdata[3:0];
        s_d.swrst = pwdata[`MCA_C_SWRST];
      end
      else if (paddr == `MCA_A_POL)
      begin
        s_d.pol = pwdata[`MCA_NDIV-1:0];
      end
      else if (paddr == `MCA_A_ACDIV)
      begin
        s_d.ac_ratio = pwdata[7:0];
      end
      else if (paddr == `MCA_A_ACPH)
      begin
        s_d.ac_phase = pwdata[7:0];
      end
      else if ((paddr & `MCA_A_PAGE) == `MCA_A_DVAL)
      begin
        s_d.dval[widx] = pwdata;
      end
      else if ((paddr & `MCA_A_PAGE) == `MCA_A_SEL)
      begin
        s_d.sel[widx] = pwdata[`MCA_SELW-1:0];
      end
    end
    if (access)
    begin
      s_d.pready = 1'b0;
    end
  end

  // ************************************************************
  // state register
  // ************************************************************
  always_ff @(posedge pclk or negedge presetn)
  begin
    if (!presetn)
    begin
      s_q <= '0;
    end
    else
    begin
      s_q <= s_d;
    end
  end

  assign prdata                  = s_q.prdata;
  assign pready                  = s_q.pready;
  assign pslverr                 = s_q.pslverr;
  assign out_pin                 = s_q.pin;
  assign trig_event              = s_q.trig;
  assign seq_trigger             = s_q.seqt;
  assign divider_clock_generator = s_q.tog;
  assign ac_trigger              = s_q.ac_pls;

endmodule

// File: dv/mca_chk_assertions.sv
// port checker of the divider, selector and ac sync block
`timescale 1ns/1ps
module mca_chk (
  input wire logic        pclk,
  input wire logic        presetn,
  input wire logic        psel,
  input wire logic        penable,
  input wire logic        pwrite,
  input wire logic [31:0] prdata,
  input wire logic        pready,
  input wire logic        pslverr,
  input wire logic        div_reset_in,
  input wire logic [7:0]  divider_clock_generator,
  input wire logic [7:0]  seq_trigger,
  input wire logic [7:0]  trig_event,
  input wire logic        ac_trigger
);
  // ****
  // properties
  // ****
  default clocking @(posedge pclk); endclocking
  default disable iff (!presetn);
  property p_rdy_setup; psel && !penable |=> pready; endproperty
  property p_rdy_one; pready |=> !pready; endproperty
  property p_err_rd; pslverr && !pwrite |-> pready && prdata == 32'h0000_0000; endproperty
  property p_seq_rise; $rose(divider_clock_generator[0]) |=> seq_trigger[0]; endproperty
  property p_trig_rise; $rose(divider_clock_generator[1]) |=> trig_event[1]; endproperty
  property p_seq_cause;
    seq_trigger[2] |-> $past(divider_clock_generator[2]) && !$past(divider_clock_generator[2], 2);
  endproperty
  property p_rst_hold; div_reset_in [*8] |=> $stable(divider_clock_generator); endproperty
  property p_ac_pulse; ac_trigger |=> !ac_trigger; endproperty
  a_rdy_setup: assert property (p_rdy_setup) else $error("ready missing after setup");
  a_rdy_one: assert property (p_rdy_one) else $error("ready longer than one cycle");
  a_err_rd: assert property (p_err_rd) else $error("refused read not zero");
  a_seq_rise: assert property (p_seq_rise) else $error("sequencer pulse missing");
  a_trig_rise: assert property (p_trig_rise) else $error("trigger pulse missing");
  a_seq_cause: assert property (p_seq_cause) else $error("pulse without rising edge");
  a_rst_hold: assert property (p_rst_hold) else $error("divider moved in reset");
  a_ac_pulse: assert property (p_ac_pulse) else $error("ac trigger too long");
  c_err: cover property (pslverr);
  c_ac: cover property (ac_trigger);
  c_seq: cover property (seq_trigger[0]);
endmodule

bind mca_top mca_chk u_chk (.pclk(pclk), .presetn(presetn), .psel(psel), .penable(penable), .pwrite(pwrite),
  .prdata(prdata), .pready(pready), .pslverr(pslverr), .div_reset_in(div_reset_in),
  .divider_clock_generator(divider_clock_generator), .seq_trigger(seq_trigger), .trig_event(trig_event),
  .ac_trigger(ac_trigger));

// File: dv/mca_far_end.sv
// far side model: trigger encoder and sequencer counting incoming pulses
`timescale 1ns/1ps
module mca_far_end (
  input  wire logic        pclk,
  input  wire logic        presetn,
  input  wire logic [7:0]  trig_event,
  input  wire logic [7:0]  seq_trigger,
  output logic      [15:0] n_trig0,
  output logic      [15:0] n_seq0
);
  // ****
  // pulse counters
  // ****
  // one count per pulse
  always_ff @(posedge pclk or negedge presetn)
  begin
    if (!presetn)
    begin
      n_trig0 <= 16'h0000;
      n_seq0  <= 16'h0000;
    end
    else
    begin
      n_trig0 <= n_trig0 + 16'(trig_event[0]);
      n_seq0  <= n_seq0 + 16'(seq_trigger[0]);
    end
  end
endmodule

// File: dv/mux_counter_output_ac_sync_test.sv
// self-checking bench of the divider, selector and ac sync block
`timescale 1ns/1ps
`define CHK(n,e,g) begin n_tests++; if ((g)!==(e)) begin failures++; $display("MISMATCH %s exp %0h got %0h", n, e, g); end end
module mux_counter_output_ac_sync_test;
  logic        pclk = 0, presetn = 0, psel = 0, penable = 0, pwrite = 0, ac_line_in = 0, div_reset_in = 0;
  logic [11:0] paddr = 12'h000;
  logic [31:0] pwdata = 32'h0000_0000, prdata, rd;
  logic        pready, pslverr, err, ac_trigger;
  logic [7:0]  shared_bus_in = 8'h81, out_pin, trig_event, seq_trigger, dcg;
  logic [15:0] n_trig0, n_seq0, c0, hi;
  int          failures = 0, n_tests = 0, i, k, v, np;
  // selector code beside the level expected on pin 0
  logic [6:0]  rows [9] = '{{6'h20, 1'b1}, {6'h21, 1'b0}, {6'h27, 1'b1}, {6'h28, 1'b0}, {6'h2F, 1'b1},
                            {6'h3E, 1'b1}, {6'h3F, 1'b0}, {6'h00, 1'b0}, {6'h31, 1'b0}};
  always #4 pclk = ~pclk;
  // shorter tick and step keep the phase delay within a short run
  mca_top #(.TICK_DIV(4), .STEP_TICKS(2)) u_dut (.pclk(pclk), .presetn(presetn), .psel(psel),
    .penable(penable), .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .prdata(prdata), .pready(pready),
    .pslverr(pslverr), .shared_bus_in(shared_bus_in), .ac_line_in(ac_line_in), .div_reset_in(div_reset_in),
    .out_pin(out_pin), .trig_event(trig_event), .seq_trigger(seq_trigger), .divider_clock_generator(dcg),
    .ac_trigger(ac_trigger));
  mca_far_end u_far (.pclk(pclk), .presetn(presetn), .trig_event(trig_event), .seq_trigger(seq_trigger),
    .n_trig0(n_trig0), .n_seq0(n_seq0));
  // ****
  // tasks
  // ****
  task final_report;
    $display("checks %0d mismatches %0d", n_tests, failures);
    if (failures == 0 && n_tests > 0)
      $display("Testbench passed");
    else
      $display("Testbench failed");
    $finish;
  endtask
  task tmo(input int t);
    if (t >= 20)
    begin
      failures++;
      final_report();
    end
  endtask
  task automatic apb(input logic w, input logic [11:0] a, input logic [31:0] d);
    int t;
    @(posedge pclk);
    psel <= 1; penable <= 0; pwrite <= w; paddr <= a; pwdata <= d;
    @(posedge pclk);
    penable <= 1;
    t = 0;
    do
    begin
      @(posedge pclk);
      t++;
    end while (pready !== 1'b1 && t < 20);
    tmo(t);
    rd = prdata; err = pslverr; psel <= 0; penable <= 0;
  endtask
  initial
  begin
    repeat (20000) @(posedge pclk);
    failures++;
    final_report();
  end
  // ****
  // main sequence
  // ****
  initial
  begin
    repeat (10) @(posedge pclk);
    presetn <= 1;
    apb(0, 12'h040, 32'h0000_0000);
    `CHK("sel0_reset", 32'h0000_0000, rd)
    `CHK("out_reset", 8'h00, out_pin)
    apb(0, 12'h0F0, 32'h0000_0000);
    `CHK("unmapped_err", 1'b1, err)
    apb(1, 12'h008, 32'h0000_0080);
    div_reset_in <= 1;
    repeat (10) @(posedge pclk);
    `CHK("reset_level", 8'h80, dcg)
    for (i = 0; i < 9; i++)
    begin
      apb(1, 12'h040, {26'h000_0000, rows[i][6:1]});
      repeat (3) @(posedge pclk);
      `CHK("out_pin0", rows[i][0], out_pin[0])
    end
    apb(1, 12'h04C, 32'h0000_003E);
    repeat (3) @(posedge pclk);
    `CHK("out_pin3", 8'h08, out_pin)
    div_reset_in <= 0;
    repeat (8) @(posedge pclk);
    for (k = 0; k < 4; k++)
    begin
      v = k + 2;
      apb(1, 12'h020, 32'(v));
      apb(0, 12'h020, 32'h0000_0000);
      `CHK("dval_rb", 32'(v), rd)
      apb(1, 12'h000, 32'h0000_0001);
      repeat (6) @(posedge pclk);
      hi = 16'h0000;
      c0 = n_seq0;
      repeat (60)
      begin
        @(posedge pclk);
        hi += 16'(dcg[0]);
      end
      // odd values stretch the second half after reset, the high half with polarity 0
      `CHK("high_cycles", 16'(60 / v * (v - (v >> 1))), hi)
      `CHK("periods", 16'(60 / v), 16'(n_seq0 - c0))
    end
    // a divide value written mid-half waits for the reload
    apb(1, 12'h020, 32'h0000_0028);
    apb(1, 12'h000, 32'h0000_0001);
    apb(1, 12'h020, 32'h0000_0004);
    repeat (16) @(posedge pclk);
    `CHK("old_half", 1'b0, dcg[0])
    repeat (3) @(posedge pclk);
    `CHK("old_half_end", 1'b1, dcg[0])
    repeat (2) @(posedge pclk);
    `CHK("new_half", 1'b0, dcg[0])
    // dividers held so trigger 0 counts only the ac source
    div_reset_in <= 1;
    // let the filtered reset take hold so no late divider edge reaches trigger 0
    repeat (8) @(posedge pclk);
    apb(1, 12'h000, 32'h0000_000A);
    c0 = n_trig0;
    ac_line_in <= 1;
    k = 0;
    while (ac_trigger !== 1'b1 && k < 20)
    begin
      @(posedge pclk);
      k++;
    end
    tmo(k);
    `CHK("bypass_fast", 1'b1, k <= 6)
    repeat (3) @(posedge pclk);
    `CHK("trig0_ac", 16'h0001, 16'(n_trig0 - c0))
    ac_line_in <= 0;
    apb(1, 12'h00C, 32'h0000_0002);
    apb(1, 12'h010, 32'h0000_0003);
    apb(1, 12'h000, 32'h0000_0000);
    np = 0;
    repeat (4)
    begin
      ac_line_in <= 1;
      for (i = 0; i < 48; i++)
      begin
        @(posedge pclk);
        if (i == 24)
          ac_line_in <= 0;
        if (ac_trigger === 1'b1)
        begin
          np++;
          `CHK("ac_delay", 1'b1, i >= 24 && i <= 40)
        end
      end
    end
    `CHK("ac_ratio", 2, np)
    // ac edge held back until divider 7 rises, also routed to pin 0
    apb(1, 12'h03C, 32'h0000_0008);
    apb(1, 12'h040, 32'h0000_0030);
    div_reset_in <= 0;
    apb(1, 12'h000, 32'h0000_0006);
    repeat (8) @(posedge pclk);
    ac_line_in <= 1;
    k = 0;
    while (ac_trigger !== 1'b1 && k < 20)
    begin
      @(posedge pclk);
      k++;
    end
    tmo(k);
    `CHK("ac_sync7", 1'b1, seq_trigger[7])
    @(posedge pclk);
    `CHK("out_ac", 1'b1, out_pin[0])
    final_report();
  end
endmodule
